/* File: tdb_burst.sv */
/*
 * tdb_burst: burst access engine of the advanced timer. Holds the burst
 * control register, the mode/status register and the burst data port,
 * and turns each data port access into one or two accesses of
 * consecutive timer registers.
 * Assumes: one AHB-Lite master, single word transfers only, hready of
 * the bus tied to hreadyout; only haddr[7:0] is decoded and hsize is
 * ignored. The timer register file writes on the clock edge that ends
 * a cycle with tgt.wr high and presents the addressed register on
 * tgt_rdata during a cycle with tgt.rd high (combinational read).
 * Bus timing: control and mode registers answer with no wait state; a
 * data port access holds hreadyout low for two cycles with 16-bit data
 * and three cycles with 8-bit data, one cycle per register strobe plus
 * one to launch the first strobe.
 * Limitations: burst_length above seventeen is not clamped; with 8-bit
 * data and an odd register count the low byte of the last datum falls
 * past the end of the burst into the next register; reads of the data port always
 * return the target register, never the value last written.
 */
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps

// Contract
// - burst_base_offset in bits 4:0 of dma_burst_control picks the first target register counted from control register one.
// - burst_length in bits 12:8 plus one is the number of register transfers per burst, one to eighteen; the code does not clamp it, so up to thirty-two.
// - every read or write of burst_data_port becomes an access of the currently selected timer register.
// - the target is control register one plus burst_base_offset plus the running index.
// - in 16-bit mode a datum goes to one register, in 8-bit mode the upper byte goes to one register and the lower byte to the next.
// - the sum of offset and index is scaled by four bytes to give the target address.
// - burst_data_port is a 16-bit register reset to zero whose accesses are redirected to the target.
module tdb_burst (
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   input  wire tdb_pkg::tdb_ahb_in_s  ahb_in,
   output tdb_pkg::tdb_ahb_out_s      ahb_out,
   output tdb_pkg::tdb_tgt_s          tgt_out,
   input  wire logic [15:0]           tgt_rdata
);
   import tdb_pkg::*;

   // all state of the engine, registered as one word
   typedef struct packed {
      tdb_state_e   st;         // access sequencer
      // dma_burst_control fields and the 8-bit data switch
      logic [4:0]   base;
      logic [4:0]   len;
      logic         byte_mode;
      // running index into the burst, and the last port datum
      logic [4:0]   idx;
      logic [15:0]  port_val;
      // pending register write, or direction of a port access
      logic         wr_pend;
      logic [7:0]   aoff;       // offset of the last address phase
      // registered bus answer and target strobes
      tdb_ahb_out_s ahb;
      tdb_tgt_s     tgt;
   } tdb_regs_s;

   tdb_regs_s cur_ff;
   tdb_regs_s nxt_cur;

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // byte address of the register at offset base + index
   function automatic logic [7:0] tdb_tgt_addr(input logic [4:0] base,
                                                input logic [4:0] idx);
      logic [7:0] sum;
      sum = {3'h0, base} + {3'h0, idx};
      return TDB_CTRL1_ADDR + (sum << TDB_STEP_SHIFT);
   endfunction : tdb_tgt_addr

   // index after a port access; wraps once the burst is used up
   function automatic logic [4:0] tdb_next_idx(input logic [4:0] idx,
                                                input logic [4:0] len,
                                                input logic       byte_mode);
      logic [5:0] nxt;
      logic [5:0] count;
      nxt   = {1'b0, idx} + (byte_mode ? 6'h02 : 6'h01);
      count = {1'b0, len} + 6'h01;
      return (nxt >= count) ? 5'h00 : nxt[4:0];
   endfunction : tdb_next_idx

   // one decode of a byte offset, shared by every register select
   function automatic logic tdb_hit(input logic [7:0] addr,
                                    input logic [7:0] ofs);
      return (addr == ofs);
   endfunction : tdb_hit

   // one byte of a datum, zero extended, for the 8-bit register pair
   function automatic logic [15:0] tdb_byte_lane(input logic [15:0] data,
                                                 input logic        upper);
      logic [7:0] lane;
      lane = upper ? data[15:8] : data[7:0];
      return {8'h00, lane};
   endfunction : tdb_byte_lane

   // read-back word of dma_burst_control; reserved bits read zero
   function automatic logic [31:0] tdb_ctrl_word(input logic [4:0] base,
                                                 input logic [4:0] len);
      logic [31:0] w;
      w                    = 32'h0000_0000;
      w[TDB_BASE_LSB +: 5] = base;
      w[TDB_LEN_LSB +: 5]  = len;
      return w;
   endfunction : tdb_ctrl_word

   // read-back word of the mode/status register
   function automatic logic [31:0] tdb_mode_word(input logic       byte_mode,
                                                 input logic [4:0] idx);
      logic [31:0] w;
      w                   = 32'h0000_0000;
      w[TDB_BYTE_BIT]     = byte_mode;
      w[TDB_IDX_LSB +: 5] = idx;
      return w;
   endfunction : tdb_mode_word

   // read result: whole register, or the byte pair rebuilt high first
   function automatic logic [15:0] tdb_read_word(input logic        byte_mode,
                                                 input logic [15:0] first,
                                                 input logic [15:0] rdata);
      logic [15:0] w;
      w = byte_mode ? {first[15:8], rdata[7:0]} : rdata;
      return w;
   endfunction : tdb_read_word

   ////////////////////////////////////////////////////////////////////////////
   // next state

   // cycle walk of a 16-bit data port write, edge n ends cycle n:
   //   c0  address phase taken at edge 0, sequencer goes to PORT_A
   //   c1  hreadyout low, master puts hwdata; target strobe launched
   //   c2  tgt.wr high at base plus index; the target writes at edge 2
   //   c3  hreadyout high again, index stepped; master done at edge 3
   // a read is the same with tgt.rd in c2 and hrdata standing in c3;
   // 8-bit data adds one cycle with the second strobe at index plus one

   // taken address phase; hready low means the bus is still stalled
   logic addr_phase;
   assign addr_phase = ahb_in.hsel && ahb_in.htrans[1] && ahb_in.hready;

   // offset decode of the address phase and of the pending write
   logic sel_dctrl;
   logic sel_port;
   logic sel_mode;
   logic pend_dctrl;
   logic pend_mode;
   assign sel_dctrl  = tdb_hit(ahb_in.haddr[7:0], TDB_OFS_DCTRL);
   assign sel_port   = tdb_hit(ahb_in.haddr[7:0], TDB_OFS_DPORT);
   assign sel_mode   = tdb_hit(ahb_in.haddr[7:0], TDB_OFS_MODE);
   assign pend_dctrl = tdb_hit(cur_ff.aoff, TDB_OFS_DCTRL);
   assign pend_mode  = tdb_hit(cur_ff.aoff, TDB_OFS_MODE);

   // one pass over the whole state word; strobes default to idle
   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.ahb.hresp = TDB_HRESP_OKAY;
      nxt_cur.tgt.wr    = 1'b0;
      nxt_cur.tgt.rd    = 1'b0;
      // sequencer:
      //   IDLE      register accesses, pending writes, port address phase
      //   PORT_A    first target strobe at base plus index
      //   PORT_B    second strobe of an 8-bit pair at index plus one
      //   PORT_END  read result captured, index stepped, bus released
      case (cur_ff.st)
         TDB_ST_IDLE: begin
            // register writes land at the end of their data phase
            if (cur_ff.wr_pend) begin
               nxt_cur.wr_pend = 1'b0;
               if (pend_dctrl) begin
                  nxt_cur.base = ahb_in.hwdata[TDB_BASE_LSB +: 5];
                  nxt_cur.len  = ahb_in.hwdata[TDB_LEN_LSB +: 5];
                  nxt_cur.idx  = 5'h00;  // new setup starts a fresh burst
               end else if (pend_mode) begin
                  nxt_cur.byte_mode = ahb_in.hwdata[TDB_BYTE_BIT];
                  nxt_cur.idx       = 5'h00;
               end
            end
            nxt_cur.ahb.hreadyout = 1'b1;
            nxt_cur.ahb.hrdata    = 32'h0000_0000;
            if (addr_phase) begin
               nxt_cur.aoff = ahb_in.haddr[7:0];
               if (sel_port) begin
                  // data port: stall until the target access is done
                  nxt_cur.ahb.hreadyout = 1'b0;
                  nxt_cur.tgt.wdata     = {15'h0000, ahb_in.hwrite};
                  nxt_cur.st            = TDB_ST_PORT_A;
               end else if (ahb_in.hwrite) begin
                  nxt_cur.wr_pend = 1'b1;
               end else if (sel_dctrl) begin
                  nxt_cur.ahb.hrdata = tdb_ctrl_word(cur_ff.base, cur_ff.len);
               end else if (sel_mode) begin
                  nxt_cur.ahb.hrdata = tdb_mode_word(cur_ff.byte_mode, cur_ff.idx);
               end
            end
         end
         TDB_ST_PORT_A: begin
            // tgt.wdata[0] carries the captured hwrite until now
            nxt_cur.tgt.addr = tdb_tgt_addr(cur_ff.base, cur_ff.idx);
            if (cur_ff.tgt.wdata[0]) begin
               nxt_cur.tgt.wr       = 1'b1;
               nxt_cur.port_val     = ahb_in.hwdata[15:0];
               nxt_cur.tgt.wdata    = cur_ff.byte_mode ?
                                      tdb_byte_lane(ahb_in.hwdata[15:0], 1'b1) :
                                      ahb_in.hwdata[15:0];
            end else begin
               nxt_cur.tgt.rd    = 1'b1;
               nxt_cur.tgt.wdata = 16'h0000;
            end
            nxt_cur.wr_pend = cur_ff.tgt.wdata[0];  // remembers direction
            nxt_cur.st = cur_ff.byte_mode ? TDB_ST_PORT_B : TDB_ST_PORT_END;
         end
         TDB_ST_PORT_B: begin
            // second half of an 8-bit pair goes to the next register
            nxt_cur.tgt.addr = tdb_tgt_addr(cur_ff.base,
                                            cur_ff.idx + 5'h01);
            if (cur_ff.wr_pend) begin
               nxt_cur.tgt.wr    = 1'b1;
               nxt_cur.tgt.wdata = tdb_byte_lane(ahb_in.hwdata[15:0], 1'b0);
            end else begin
               nxt_cur.tgt.rd    = 1'b1;
               nxt_cur.port_val  = {tgt_rdata[7:0], 8'h00};
            end
            nxt_cur.st = TDB_ST_PORT_END;
         end
         TDB_ST_PORT_END: begin
            if (!cur_ff.wr_pend) begin
               // read result: whole register, or the byte pair rebuilt
               nxt_cur.port_val = tdb_read_word(cur_ff.byte_mode,
                                                cur_ff.port_val,
                                                tgt_rdata);
               nxt_cur.ahb.hrdata = {16'h0000, nxt_cur.port_val};
            end
            nxt_cur.wr_pend       = 1'b0;
            nxt_cur.idx           = tdb_next_idx(cur_ff.idx, cur_ff.len,
                                                 cur_ff.byte_mode);
            nxt_cur.ahb.hreadyout = 1'b1;
            nxt_cur.st            = TDB_ST_IDLE;
         end
         default: begin
            nxt_cur.st = TDB_ST_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register

   // reset loads constants only; bus ready at once so the first address
   // phase after release is taken
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cur_ff.st            <= TDB_ST_IDLE;
         cur_ff.base          <= TDB_DCTRL_RST[TDB_BASE_LSB +: 5];
         cur_ff.len           <= TDB_DCTRL_RST[TDB_LEN_LSB +: 5];
         cur_ff.byte_mode     <= TDB_BYTE_RST;
         cur_ff.idx           <= 5'h00;
         cur_ff.port_val      <= TDB_DPORT_RST;
         cur_ff.wr_pend       <= 1'b0;
         cur_ff.aoff          <= 8'h00;
         cur_ff.ahb.hrdata    <= 32'h0000_0000;
         cur_ff.ahb.hreadyout <= 1'b1;
         cur_ff.ahb.hresp     <= TDB_HRESP_OKAY;
         cur_ff.tgt           <= '0;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   // all outputs straight from the state flops
   assign ahb_out = cur_ff.ahb;
   assign tgt_out = cur_ff.tgt;

endmodule : tdb_burst

/* File: tdb_burst_assertions.sv */
/* checker of the burst engine ports; sees only tdb_burst top ports.
   Assumes hready tied to hreadyout and one clock domain, hclk. */
`timescale 1ns/1ps
module tdb_burst_assertions (
   input wire logic                  hclk,
   input wire logic                  hresetn,
   input wire tdb_pkg::tdb_ahb_in_s  ahb_in,
   input wire tdb_pkg::tdb_ahb_out_s ahb_out,
   input wire tdb_pkg::tdb_tgt_s     tgt_out,
   input wire logic [15:0]           tgt_rdata
);
   import tdb_pkg::*;
   logic tk;
   logic prt;
   // taken address phases, data port ones apart
   assign tk  = ahb_in.hsel && ahb_in.htrans[1] && ahb_in.hready;
   assign prt = tk && (ahb_in.haddr[7:0] == TDB_OFS_DPORT);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   chk_resp_okay: assert property (ahb_out.hresp == TDB_HRESP_OKAY)
      else $error("response not okay");
   chk_strobe_excl: assert property (!(tgt_out.wr && tgt_out.rd))
      else $error("read and write strobes together");
   chk_addr_word: assert property ((tgt_out.wr || tgt_out.rd) |-> tgt_out.addr[1:0] == 2'h0)
      else $error("target address not word aligned");
   chk_port_stall: assert property (prt |=> !ahb_out.hreadyout)
      else $error("port access without wait state");
   chk_port_done: assert property (prt |=> ##[2:3] ahb_out.hreadyout)
      else $error("port access not finished in time");
   chk_strobe_busy: assert property ((tgt_out.wr || tgt_out.rd) |-> !ahb_out.hreadyout)
      else $error("target strobe outside port access");
   chk_ctrl_nowait: assert property (tk && ahb_in.haddr[7:0] == TDB_OFS_DCTRL |=> ahb_out.hreadyout)
      else $error("control access stalled");
   chk_rdata_upper: assert property (ahb_out.hrdata[31:16] == 16'h0)
      else $error("upper read data not zero");
   chk_port_write: assert property (prt && ahb_in.hwrite |=> ##1 tgt_out.wr)
      else $error("port write gave no target write");
endmodule : tdb_burst_assertions
////////////////////////////////////////////////////////////////////////
bind tdb_burst tdb_burst_assertions i_chk (.hclk(hclk), .hresetn(hresetn), .ahb_in(ahb_in),
   .ahb_out(ahb_out), .tgt_out(tgt_out), .tgt_rdata(tgt_rdata));

/* File: tdb_pkg.sv */
/*
 * tdb_pkg: constants, bus carriers and state types of the timer burst
 * access engine. Assumes an AHB-Lite register bus with 32-bit data and a
 * timer register file reached through the tdb_tgt_s access port.
 */
package tdb_pkg;

   // register map, byte offsets inside the timer window
   localparam logic [7:0]  TDB_OFS_DCTRL   = 8'h48;
   localparam logic [7:0]  TDB_OFS_DPORT   = 8'h4c;
   localparam logic [7:0]  TDB_OFS_MODE    = 8'h50;
   // address of control register one inside the timer window
   localparam logic [7:0]  TDB_CTRL1_ADDR  = 8'h00;

   // field positions of dma_burst_control
   localparam int          TDB_BASE_LSB    = 0;
   localparam int          TDB_LEN_LSB     = 8;
   // field positions of the mode/status register
   localparam int          TDB_BYTE_BIT    = 0;
   localparam int          TDB_IDX_LSB     = 8;

   // reset values
   localparam logic [15:0] TDB_DCTRL_RST   = 16'h0000;
   localparam logic [15:0] TDB_DPORT_RST   = 16'h0000;
   localparam logic        TDB_BYTE_RST    = 1'b0;

   // one register step is one 32-bit word
   localparam int          TDB_STEP_SHIFT  = 2;

   // ahb encodings
   localparam logic [1:0]  TDB_HTRANS_NSEQ = 2'h2;
   localparam logic        TDB_HRESP_OKAY  = 1'b0;

   typedef enum logic [1:0] {
      TDB_ST_IDLE,
      TDB_ST_PORT_A,
      TDB_ST_PORT_B,
      TDB_ST_PORT_END
   } tdb_state_e;

   // ahb-lite inputs of the slave
   typedef struct packed {
      logic        hsel;
      logic [31:0] haddr;
      logic [1:0]  htrans;
      logic        hwrite;
      logic [2:0]  hsize;
      logic [31:0] hwdata;
      logic        hready;
   } tdb_ahb_in_s;

   // ahb-lite outputs of the slave
   typedef struct packed {
      logic [31:0] hrdata;
      logic        hreadyout;
      logic        hresp;
   } tdb_ahb_out_s;

   // access port towards the timer register file
   typedef struct packed {
      logic [7:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } tdb_tgt_s;

endpackage : tdb_pkg

/* File: tdb_regfile.sv */
/* timer register file model on the target port; no reset, reads are
   combinational while rd is high */
`timescale 1ns/1ps
module tdb_regfile (
   input wire logic              hclk,
   input wire tdb_pkg::tdb_tgt_s tgt,
   output logic [15:0]           rdata
);
   import tdb_pkg::*;
   logic [15:0] mem [64];
   logic [15:0] last;
   // write at the edge ending the strobe, remember last read
   always_ff @(posedge hclk) begin
      if (tgt.wr) mem[tgt.addr[7:2]] <= tgt.wdata;
      if (tgt.rd) last <= mem[tgt.addr[7:2]];
   end
   // not selected: show the inverse so stale data cannot pass
   assign rdata = tgt.rd ? mem[tgt.addr[7:2]] : ~last;
endmodule : tdb_regfile

/* File: timer_dma_burst_control_test.sv */
/* testbench of tdb_burst with the register file model as target; an
   AHB-Lite master drives single word transfers and every target strobe
   is checked against a queue of notes. Assumes hready tied to hreadyout
   and a combinational read in the register file model. */
`timescale 1ns/1ps
module timer_dma_burst_control_test;
   import tdb_pkg::*;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
   logic [31:0] haddr = 0, hwdata = 0, r, d;
   logic [1:0]  htrans = 0;
   logic [15:0] trd, v, dat [64];
   logic [24:0] q [$];
   tdb_ahb_in_s  ai;
   tdb_ahb_out_s ao;
   tdb_tgt_s     to;
   int          mismatches = 0, total_checks = 0, b, l, m, n, s, x;
   assign ai = '{hsel, haddr, htrans, hwrite, 3'h2, hwdata, ao.hreadyout};
   tdb_burst i_tdb_burst (.hclk(hclk), .hresetn(hresetn), .ahb_in(ai), .ahb_out(ao),
      .tgt_out(to), .tgt_rdata(trd));
   tdb_regfile i_tdb_regfile (.hclk(hclk), .tgt(to), .rdata(trd));
   initial forever #25 hclk = ~hclk;
   ////////////////////////////////////////////////////////////////////
   task end_sim;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_sim
   task check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // wait for hready, judged before the edge where the master samples it
   task rdy;
      logic k;
      int   c;
      c = 0;
      do begin
         @(negedge hclk);
         k = ao.hreadyout;
         r = ao.hrdata;
         @(posedge hclk);
         c++;
         if (c > 20) begin
            mismatches++;
            end_sim;
         end
      end while (k !== 1'b1);
   endtask : rdy
   task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= TDB_HTRANS_NSEQ;
      hwrite <= w;
      rdy;
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      rdy;
   endtask : bus
   // monitor: each target strobe against the oldest note
   always @(negedge hclk) if (to.wr || to.rd) begin
      if (q.size() == 0) check(1, 0);
      else check({to.addr, to.wr ? to.wdata : 16'h0, to.wr}, q.pop_front());
   end
   ////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h4716dc37));
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      bus(0, TDB_OFS_DCTRL, 0);
      check(r, 32'h0);
      // 16-bit short burst, 16-bit longest burst, 8-bit burst
      for (m = 0; m < 3; m++) begin
         b = $urandom_range(7);
         l = (m == 1) ? 17 : 3;
         s = (m == 2) ? 2 : 1;
         n = (l + 1) / s;
         bus(1, TDB_OFS_MODE, m == 2);
         bus(1, TDB_OFS_DCTRL, 32'hffff_e0e0 | (l << 8) | b);
         bus(0, TDB_OFS_DCTRL, 0);
         check(r, (l << 8) | b);
         for (int k = 0; k <= n; k++) begin  // one extra write wraps the index
            x = (k * s) % (l + 1); d = $urandom;
            for (int j = 0; j < s; j++) begin
               v = (s == 1) ? d[15:0] : (j ? {8'h0, d[7:0]} : {8'h0, d[15:8]});
               dat[x + j] = v;
               q.push_back({8'((b + x + j) * 4), v, 1'b1});
            end
            bus(1, TDB_OFS_DPORT, d);
         end
         // index left by the extra write, and the data width switch
         bus(0, TDB_OFS_MODE, 0);
         check(r, (((n + 1) * s % (l + 1)) << TDB_IDX_LSB) | (m == 2));
         bus(1, TDB_OFS_DCTRL, (l << 8) | b);
         for (int k = 0; k < n; k++) begin
            x = k * s;
            for (int j = 0; j < s; j++) q.push_back({8'((b + x + j) * 4), 16'h0, 1'b0});
            bus(0, TDB_OFS_DPORT, 0);
            check(r, (s == 1) ? dat[x] : {dat[x][7:0], dat[x + 1][7:0]});
         end
      end
      bus(1, 8'h60, 32'hffff_ffff);
      bus(0, 8'h60, 0);
      check(r, 32'h0);
      // reset in mid-run: setup and width switch back to zero; index reads zero, as it already did before reset
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      bus(0, TDB_OFS_DCTRL, 0);
      check(r, 32'h0);
      bus(0, TDB_OFS_MODE, 0);
      check(r, 32'h0);
      check(q.size(), 0);
      end_sim;
   end
endmodule : timer_dma_burst_control_test
